// ---- ccdc_device.sv ----
// Conditioner end: 81-bit shift register, active word, decoders.
// Assumes the host keeps shift enable high only while shifting.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Configuration held in 81-bit shift register
// - Host sends least significant bit first
// - Serial output shows register, LSB first
// - Host supplies the shift clock
// - Shift one bit per clock when enabled
// - Enable low: shifting stops, contents held
// - Update strobe applies shifted word
// - Feedback select: ground, oscillator, delayed, unused
// - Single-ended: one of pads 1,2,4 chosen
// - Differential: pads 1+2 pair, pad 3 paired
// - Mux tree picks pad or internal clock
// - Word sets feedback, source and pad mode selectors
module ccdc_device
   import ccdc_pkg::*;
#(
   parameter int WIDTH = CFG_BITS
)
(
   input  wire logic             clk,
   input  wire logic             nrst,
   ccdc_if.device                link,
   input  wire logic [3:0]       padIn,
   input  wire logic             internalClk,
   output logic [WIDTH-1:0]      activeCfg,
   output ccdc_fb_t              feedbackMuxSelect,
   output logic                  feedbackPowerDown,
   output logic                  referenceClockIn,
   output logic [3:0]            padIsRegularIo
);
   logic [WIDTH-1:0] shiftReg_ff;
   logic [WIDTH-1:0] nxt_shiftReg;
   logic [WIDTH-1:0] activeCfg_ff;
   logic [WIDTH-1:0] nxt_activeCfg;
   logic             doShift;
   logic             doApply;
   ccdc_src_t        srcSel;
   logic             diffMode;
   logic [3:0]       padRx;
   logic [3:0]       padClaim;
   logic [3:0]       padLead;
   logic             padClk;

   // Pads a source setting takes; leadOnly keeps just the receiving pad
   function automatic logic [3:0] pad_claim
   (
      input ccdc_src_t src,
      input logic      diff,
      input logic      leadOnly
   );
      logic [3:0] mask;
      mask = 4'h0;
      case (src)
         SRC_PAD_FIRST:
            mask = (diff && !leadOnly) ? 4'h3 : 4'h1;
         SRC_PAD_SECOND:
            mask = !diff ? 4'h2 : (leadOnly ? 4'h4 : 4'hC);
         SRC_PAD_FOURTH:
            mask = 4'h8;
         default:
            mask = 4'h0;
      endcase
      return mask;
   endfunction

   assign doShift = link.cfgShiftEnable & link.cfgShiftClkEn;
   assign doApply = link.cfgApplyStrobe;

   // One stage per bit: the serial chain and the word it feeds on apply
   for (genvar b = 0; b < WIDTH; b++)
   begin : g_bit
      logic stageIn;
      if (b == WIDTH - 1)
      begin : g_top
         assign stageIn = link.cfgSerialIn;
      end
      else
      begin : g_mid
         assign stageIn = shiftReg_ff[b+1];
      end
      assign nxt_shiftReg[b] =
         doShift ? stageIn : shiftReg_ff[b];
      assign nxt_activeCfg[b] = doApply ? shiftReg_ff[b] : activeCfg_ff[b];
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         shiftReg_ff <= CFG_RESET[WIDTH-1:0];
      else
         shiftReg_ff <= nxt_shiftReg;
   end

   // Active word only moves on the strobe, so partial loads stay invisible
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         activeCfg_ff <= CFG_RESET[WIDTH-1:0];
      else
         activeCfg_ff <= nxt_activeCfg;
   end

   assign link.cfgSerialOut = shiftReg_ff[0];
   assign activeCfg = activeCfg_ff;

   assign feedbackMuxSelect =
      ccdc_fb_t'(activeCfg_ff[FB_SEL_LSB +: 2]);
   assign feedbackPowerDown = (feedbackMuxSelect == FB_GROUND);

   assign srcSel   = ccdc_src_t'(activeCfg_ff[IN_SEL_LSB +: 2]);
   assign diffMode = activeCfg_ff[PAD_MODE_BIT];
   assign padClaim = pad_claim(srcSel, diffMode, 1'b0);
   assign padLead  = pad_claim(srcSel, diffMode, 1'b1);

   // Even pads may be the true leg of a pair, the next pad its other leg
   for (genvar k = 0; k < 4; k++)
   begin : g_pad
      if (k % 2 == 0)
      begin : g_pair
         assign padRx[k] = diffMode ? (padIn[k] & ~padIn[k+1]) : padIn[k];
      end
      else
      begin : g_single
         assign padRx[k] = padIn[k];
      end
      assign padIsRegularIo[k] = ~padClaim[k];
   end

   // Glitch-free switching is not attempted; reconfigure while idle
   assign padClk = |(padLead & padRx);
   assign referenceClockIn =
      (srcSel == SRC_INTERNAL) ? internalClk : padClk;
endmodule
`default_nettype wire

// ---- ccdc_pkg.sv ----
// Shared constants and types for the dynamic configuration shift port.
// Assumes both ends run on one clock, clk, at 10 MHz.
package ccdc_pkg;
   localparam int CFG_BITS       = 81;
   localparam int FB_SEL_LSB     = 0;
   localparam int IN_SEL_LSB     = 2;
   localparam int PAD_MODE_BIT   = 4;
   localparam int SHIFT_DIV      = 4;
   localparam int SHIFT_DIV_W    = 2;
   localparam logic [80:0] CFG_RESET = 81'h0;

   typedef enum logic [1:0]
   {
      FB_GROUND      = 2'h0,
      FB_OSC_ZERO    = 2'h1,
      FB_OSC_DELAYED = 2'h2,
      FB_UNUSED      = 2'h3
   } ccdc_fb_t;

   typedef enum logic [1:0]
   {
      SRC_PAD_FIRST  = 2'h0,
      SRC_PAD_SECOND = 2'h1,
      SRC_PAD_FOURTH = 2'h2,
      SRC_INTERNAL   = 2'h3
   } ccdc_src_t;

   typedef enum logic [1:0]
   {
      LD_IDLE  = 2'h0,
      LD_SHIFT = 2'h1,
      LD_APPLY = 2'h2
   } ccdc_ld_t;
endpackage

// ---- ccdc_if.sv ----
// Serial configuration link between fabric logic and the conditioner.
// Assumes a common clk; the shift clock is an enable pulse on it.
`timescale 1ns/1ps
`default_nettype none
interface ccdc_if;
   logic cfgShiftClkEn;
   logic cfgSerialIn;
   logic cfgSerialOut;
   logic cfgShiftEnable;
   logic cfgApplyStrobe;

   modport device
   (
      input  cfgShiftClkEn,
      input  cfgSerialIn,
      output cfgSerialOut,
      input  cfgShiftEnable,
      input  cfgApplyStrobe
   );
   modport host
   (
      output cfgShiftClkEn,
      output cfgSerialIn,
      input  cfgSerialOut,
      output cfgShiftEnable,
      output cfgApplyStrobe
   );
endinterface
`default_nettype wire

// ---- ccdc_host.sv ----
// Fabric end: shifts a word out LSB first, reads back, then applies.
// Assumes the device samples on clk when the shift enable pulse is high.
`timescale 1ns/1ps
`default_nettype none
module ccdc_host
   import ccdc_pkg::*;
#(
   parameter int WIDTH = CFG_BITS
)
(
   input  wire logic             clk,
   input  wire logic             nrst,
   ccdc_if.host                  link,
   input  wire logic             start,
   input  wire logic [WIDTH-1:0] loadWord,
   output logic                  busy,
   output logic                  done,
   output logic [WIDTH-1:0]      readBack
);
   ccdc_ld_t               state_ff;
   ccdc_ld_t               nxt_state;
   logic [WIDTH-1:0]       word_ff;
   logic [WIDTH-1:0]       readBack_ff;
   logic [7:0]             count_ff;
   logic [SHIFT_DIV_W-1:0] div_ff;
   logic                   done_ff;
   logic                   tick;
   logic                   lastBit;

   assign tick    = (div_ff == SHIFT_DIV_W'(SHIFT_DIV - 1));
   assign lastBit = tick && (count_ff == 8'(WIDTH - 1));

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         LD_IDLE:  if (start) nxt_state = LD_SHIFT;
         LD_SHIFT: if (lastBit) nxt_state = LD_APPLY;
         LD_APPLY: nxt_state = LD_IDLE;
         default:  nxt_state = LD_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_ff    <= LD_IDLE;
         word_ff     <= '0;
         readBack_ff <= '0;
         count_ff    <= 8'h00;
         div_ff      <= '0;
         done_ff     <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         done_ff  <= (state_ff == LD_APPLY);
         if (state_ff == LD_IDLE && start)
         begin
            word_ff  <= loadWord;
            count_ff <= 8'h00;
            div_ff   <= '0;
         end
         else if (state_ff == LD_SHIFT)
         begin
            div_ff <= tick ? '0 : div_ff + 1'b1;
            if (tick)
            begin
               // Old contents come back as the new word goes in
               word_ff     <= {1'b0, word_ff[WIDTH-1:1]};
               readBack_ff <= {link.cfgSerialOut, readBack_ff[WIDTH-1:1]};
               count_ff    <= count_ff + 8'h01;
            end
         end
      end
   end

   assign link.cfgShiftClkEn  = (state_ff == LD_SHIFT) & tick;
   assign link.cfgShiftEnable = (state_ff == LD_SHIFT);
   assign link.cfgSerialIn    = word_ff[0];
   assign link.cfgApplyStrobe = (state_ff == LD_APPLY);
   assign busy     = (state_ff != LD_IDLE);
   assign done     = done_ff;
   assign readBack = readBack_ff;
endmodule
`default_nettype wire

// ---- ccdc_checker.sv ----
// Assertions on the serial link joining host and device ends.
// Assumes one clk domain and nrst asynchronous, active low.
`timescale 1ns/1ps
`default_nettype none
module ccdc_checker
#(
   parameter int WIDTH = 81
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic cfgShiftClkEn,
   input wire logic cfgSerialIn,
   input wire logic cfgSerialOut,
   input wire logic cfgShiftEnable,
   input wire logic cfgApplyStrobe
);
   logic [7:0] pulseCnt_ff;
   logic [7:0] nxt_pulseCnt;
   logic       enPrev_ff;
   wire        shiftPulse = cfgShiftEnable && cfgShiftClkEn;
   // Restart on a new shift phase, so a short phase is caught
   assign nxt_pulseCnt = (cfgShiftEnable && !enPrev_ff) ? 8'h00
                       : pulseCnt_ff + {7'h00, shiftPulse};
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pulseCnt_ff <= 8'h00;
         enPrev_ff   <= 1'b0;
      end
      else
      begin
         pulseCnt_ff <= nxt_pulseCnt;
         enPrev_ff   <= cfgShiftEnable;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_shift;
      cfgShiftEnable && cfgShiftClkEn;
   endsequence
   sequence s_gap;
      !cfgShiftClkEn [*3];
   endsequence
   a_pulse_spacing: assert property (
      cfgShiftClkEn |=> s_gap)
      else $error("shift clock pulses too close");
   a_first_pulse: assert property (
      $rose(cfgShiftEnable) |-> s_gap ##1 cfgShiftClkEn)
      else $error("first shift pulse misplaced");
   a_pulse_enabled: assert property (
      cfgShiftClkEn |-> cfgShiftEnable)
      else $error("shift pulse outside shift phase");
   a_hold_idle: assert property (
      !shiftPulse |=> $stable(cfgSerialOut))
      else $error("serial output moved without a shift");
   a_count_exact: assert property (
      $fell(cfgShiftEnable) |-> pulseCnt_ff == WIDTH)
      else $error("shift phase length wrong");
   a_apply_after: assert property (
      s_shift ##0 (pulseCnt_ff == WIDTH - 1) |=> cfgApplyStrobe)
      else $error("update strobe missing after last bit");
   a_apply_single: assert property (
      cfgApplyStrobe |=> !cfgApplyStrobe)
      else $error("update strobe too long");
   a_input_steady: assert property (
      !$stable(cfgSerialIn) |-> !cfgShiftEnable || $past(cfgShiftClkEn)
         || $rose(cfgShiftEnable))
      else $error("serial input changed between pulses");
endmodule
`default_nettype wire

// ---- clock_conditioner_dynamic_config_tb.sv ----
// Bench: host end loads words into the device end; results checked.
// Assumes the package constants and one 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module clock_conditioner_dynamic_config_tb
   import ccdc_pkg::*;
;
   logic                clk, nrst, start, internalClk, busy, done;
   logic                feedbackPowerDown, referenceClockIn;
   logic [3:0]          padIn, padIsRegularIo;
   logic [CFG_BITS-1:0] loadWord, readBack, activeCfg, prev;
   ccdc_fb_t            feedbackMuxSelect;
   int                  failures = 0, cmp_count = 0, cycles = 0;
   ccdc_if link();
   ccdc_host ccdc_host_inst (.clk(clk), .nrst(nrst), .link(link),
      .start(start), .loadWord(loadWord), .busy(busy), .done(done),
      .readBack(readBack));
   ccdc_device ccdc_device_inst (.clk(clk), .nrst(nrst), .link(link),
      .padIn(padIn), .internalClk(internalClk), .activeCfg(activeCfg),
      .feedbackMuxSelect(feedbackMuxSelect),
      .feedbackPowerDown(feedbackPowerDown),
      .referenceClockIn(referenceClockIn),
      .padIsRegularIo(padIsRegularIo));
   ccdc_checker #(.WIDTH(CFG_BITS)) ccdc_checker_inst (.clk(clk),
      .nrst(nrst), .cfgShiftClkEn(link.cfgShiftClkEn),
      .cfgSerialIn(link.cfgSerialIn), .cfgSerialOut(link.cfgSerialOut),
      .cfgShiftEnable(link.cfgShiftEnable),
      .cfgApplyStrobe(link.cfgApplyStrobe));
   task summarize;
      if (failures == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task check(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1)
      begin
         failures++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask
   // Word i: feedback and source code i for i up to 3; words 4 and 5 are differential, codes 0 and 1
   task automatic load(input int i);
      logic [4:0] c;
      logic [3:0] pads;
      int         n;
      int         idx;
      c = (i == 4) ? 5'h10 : ((i == 5) ? 5'h15 : {1'b0, 2'(i), 2'(i)});
      idx = (i == 2) ? 3 : ((i == 4) ? 0 : ((i == 5) ? 2 : i));
      pads = (i == 4) ? 4'hC : ((i == 5) ? 4'h3 : ~(4'h1 << idx));
      if (i == 3)
         pads = 4'hF;
      @(negedge clk);
      loadWord = {{19{4'hA ^ 4'(i)}}, c};
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      repeat (100) @(negedge clk);
      check(activeCfg === prev, "active word moved mid-shift");
      check(busy && link.cfgShiftEnable, "shift phase");
      n = 0;
      while (done !== 1'b1 && n < 400)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      check(done === 1'b1, "done pulse");
      check(activeCfg === loadWord, "applied word");
      check(readBack === prev, "read back word");
      check(!busy && link.cfgSerialOut === loadWord[0], "idle hold");
      check(feedbackMuxSelect === ccdc_fb_t'(c[1:0]), "feedback");
      check(feedbackPowerDown === (c[1:0] == 2'h0), "power down");
      check(padIsRegularIo === pads, "pads");
      @(negedge clk);
      padIn = 4'h1 << idx;
      internalClk = (i == 3);
      #1 check(referenceClockIn === 1'b1, "source high");
      @(negedge clk);
      padIn = ~padIn;
      internalClk = !internalClk;
      #1 check(referenceClockIn === 1'b0, "source low");
      // Both legs high: a pair must read low, a single pad high
      @(negedge clk);
      padIn = 4'h3 << idx;
      #1 check(referenceClockIn === (i < 3), "both legs high");
      prev = loadWord;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Six loads take about 2000 cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         failures++;
         summarize();
      end
   end
   initial
   begin
      nrst = 1'b0;
      start = 1'b0;
      internalClk = 1'b0;
      padIn = 4'h0;
      loadWord = '0;
      prev = CFG_RESET;
      repeat (4) @(negedge clk);
      nrst = 1'b1;
      check(activeCfg === CFG_RESET && feedbackPowerDown === 1'b1,
         "reset");
      for (int i = 0; i < 6; i++)
         load(i);
      summarize();
   end
endmodule
`default_nettype wire
